// File: core/adc_coding_pkg.sv
// ============================================================
// shared constants for the converter output coding block
// ============================================================
// holds code widths, saturation codes, overdrive limits and buffer sizes
// assumes the analog input arrives as a signed count of result lsbs
package adc_coding_pkg;

    // ========================================================
    // result word layout
    // ========================================================
    localparam int RESULT_WIDTH = 12;                   // twos-complement result bits
    localparam int MSB_POS      = 11;                   // position of the sign bit
    localparam int ANALOG_WIDTH = 16;                   // signed input model, 1 lsb units
    localparam int REF_WIDTH    = 8;                    // reference level model

    // ========================================================
    // codes
    // ========================================================
    localparam logic [11:0] CODE_ZERO     = 12'h000;    // zero differential input
    localparam logic [11:0] CODE_POS_FULL = 12'h7FF;    // largest positive code
    localparam logic [11:0] CODE_NEG_FULL = 12'h800;    // most negative code
    localparam logic [11:0] CODE_MIDSCALE = 12'h000;    // code reported on fold back

    // ========================================================
    // input thresholds, in lsbs of the result
    // ========================================================
    localparam logic signed [15:0] POS_FULL_SCALE = 16'sh07FF;  // +full scale
    localparam logic signed [15:0] NEG_FULL_SCALE = 16'shF800;  // -full scale
    localparam logic signed [15:0] FOLD_LIMIT     = 16'sh0C00;  // positive overdrive limit

    // ========================================================
    // pipeline, pin sampling and buffering
    // ========================================================
    localparam int PIPE_STAGES  = 3;                    // conversions in flight
    localparam int SYNC_STAGES  = 3;                    // flops on each async pin
    localparam int ASYNC_PINS   = 2;                    // sample clock and drive enable
    localparam int PIN_SAMPLE   = 0;                    // index of the sample clock pin
    localparam int PIN_ENABLE   = 1;                    // index of the drive enable pin
    localparam int FIFO_DEPTH   = 16;                   // buffered results
    localparam int STREAM_WIDTH = 14;                   // {discard, range flag, code}

endpackage

// File: core/result_fifo.sv
// ============================================================
// result_fifo: flop-based fifo with a registered output stage
// ============================================================
// holds WIDTH-bit words, DEPTH entries plus one output register
// assumes DEPTH is a power of two and both sides share clk
`timescale 1ns/1ps

module result_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    wr_ptr_next;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW-1:0]    rd_ptr_next;
    logic [PW:0]      count_reg;
    logic [PW:0]      count_next;
    logic             out_valid_reg;
    logic             out_valid_next;
    logic [WIDTH-1:0] out_data_reg;
    logic [WIDTH-1:0] out_data_next;
    logic             push;
    logic             pop;

    // full is honest: ready drops once every entry is taken
    assign in_ready  = (count_reg != DEPTH[PW:0]);
    assign out_valid = out_valid_reg;
    assign out_data  = out_data_reg;

    // push, pop into the output register, pointer and count updates
    always_comb
    begin
        push           = in_valid && in_ready;
        pop            = (count_reg != '0) && (!out_valid_reg || out_ready);
        wr_ptr_next    = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
        rd_ptr_next    = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
        count_next     = count_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
        out_valid_next = pop ? 1'b1 : (out_ready ? 1'b0 : out_valid_reg);
        out_data_next  = pop ? mem_reg[rd_ptr_reg] : out_data_reg;
    end

    // state registers
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_ptr_reg    <= '0;
            rd_ptr_reg    <= '0;
            count_reg     <= '0;
            out_valid_reg <= 1'b0;
            out_data_reg  <= '0;
        end
        else
        begin
            wr_ptr_reg    <= wr_ptr_next;
            rd_ptr_reg    <= rd_ptr_next;
            count_reg     <= count_next;
            out_valid_reg <= out_valid_next;
            out_data_reg  <= out_data_next;
        end
    end

    // storage, written by index; contents need no reset
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

endmodule // result_fifo

// File: core/adc_output_coding.sv
// ============================================================
// adc_output_coding: digital output side of a pipelined converter
// ============================================================
// holds the coding, saturation, three-stage latency, drive enable and
// result buffering of a 12-bit sampling converter
// assumes the sample clock and drive enable are pins from another domain,
// while the analog input and reference models come from logic on clk
`timescale 1ns/1ps

module adc_output_coding (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        sample_clock_input,
    input  wire logic        output_drive_enable,
    input  wire logic [15:0] analog_in,
    input  wire logic [7:0]  reference_level,
    output logic      [10:0] result_low_bits,
    output logic             result_msb,
    output logic             result_msb_n,
    output logic             out_of_range_flag,
    output logic             result_discard,
    output logic             result_oe,
    output logic             stream_valid,
    input  wire logic        stream_ready,
    output logic      [13:0] stream_data,
    output logic             stream_overrun
);

    // ========================================================
    // pin sampling
    // ========================================================
    logic [2:0] pin_sync_reg  [adc_coding_pkg::ASYNC_PINS];
    logic [2:0] pin_sync_next [adc_coding_pkg::ASYNC_PINS];
    logic       pin_level_reg  [adc_coding_pkg::ASYNC_PINS];
    logic       pin_level_next [adc_coding_pkg::ASYNC_PINS];
    logic [1:0] pin_raw;
    logic       sample_edge;

    assign pin_raw = {output_drive_enable, sample_clock_input};

    // three flops per pin; a level counts once the second and third agree
    for (genvar p = 0; p < adc_coding_pkg::ASYNC_PINS; p++)
    begin : g_pin
        always_comb
        begin
            pin_sync_next[p]  = {pin_sync_reg[p][1:0], pin_raw[p]};
            pin_level_next[p] = (pin_sync_reg[p][1] == pin_sync_reg[p][2])
                                ? pin_sync_reg[p][2] : pin_level_reg[p];
        end

        always_ff @(posedge clk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                pin_sync_reg[p]  <= 3'h0;
                pin_level_reg[p] <= 1'b0;
            end
            else
            begin
                pin_sync_reg[p]  <= pin_sync_next[p];
                pin_level_reg[p] <= pin_level_next[p];
            end
        end
    end

    // rising edge of the sample clock takes a sample
    assign sample_edge = pin_sync_reg[adc_coding_pkg::PIN_SAMPLE][1]
                      && pin_sync_reg[adc_coding_pkg::PIN_SAMPLE][2]
                      && !pin_level_reg[adc_coding_pkg::PIN_SAMPLE];

    // ========================================================
    // coding of a new sample
    // ========================================================
    logic signed [15:0] analog_s;
    logic [11:0]        new_code;
    logic               new_range;

    assign analog_s = signed'(analog_in);

    // saturate at both ends, fold back on heavy positive overdrive
    always_comb
    begin
        if (analog_s > adc_coding_pkg::FOLD_LIMIT)
        begin
            new_code  = adc_coding_pkg::CODE_MIDSCALE;
            new_range = 1'b1;
        end
        else if (analog_s > adc_coding_pkg::POS_FULL_SCALE)
        begin
            new_code  = adc_coding_pkg::CODE_POS_FULL;
            new_range = 1'b1;
        end
        else if (analog_s < adc_coding_pkg::NEG_FULL_SCALE)
        begin
            new_code  = adc_coding_pkg::CODE_NEG_FULL;
            new_range = 1'b1;
        end
        else
        begin
            new_code  = analog_in[11:0];
            new_range = 1'b0;
        end
    end

    // ========================================================
    // reference watch
    // ========================================================
    logic [7:0] ref_prev_reg;
    logic       ref_pending_reg;
    logic       ref_pending_next;
    logic       ref_change;
    logic       invalidate;

    // a change seen between edges is held until the next edge
    always_comb
    begin
        ref_change       = (reference_level != ref_prev_reg);
        invalidate       = sample_edge && (ref_pending_reg || ref_change);
        ref_pending_next = sample_edge ? 1'b0 : (ref_pending_reg || ref_change);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ref_prev_reg    <= 8'h00;
            ref_pending_reg <= 1'b0;
        end
        else
        begin
            ref_prev_reg    <= reference_level;
            ref_pending_reg <= ref_pending_next;
        end
    end

    // ========================================================
    // conversion pipeline
    // ========================================================
    logic [11:0] stage_code_reg  [adc_coding_pkg::PIPE_STAGES];
    logic [11:0] stage_code_next [adc_coding_pkg::PIPE_STAGES];
    logic        stage_range_reg  [adc_coding_pkg::PIPE_STAGES];
    logic        stage_range_next [adc_coding_pkg::PIPE_STAGES];
    logic        stage_bad_reg  [adc_coding_pkg::PIPE_STAGES];
    logic        stage_bad_next [adc_coding_pkg::PIPE_STAGES];

    // one stage per conversion in flight; all shift on a sample edge
    for (genvar s = 0; s < adc_coding_pkg::PIPE_STAGES; s++)
    begin : g_stage
        // stage feeding this one; stage 0 names itself so no index falls outside the array
        localparam int PREV = (s == 0) ? 0 : s - 1;

        always_comb
        begin
            stage_code_next[s]  = stage_code_reg[s];
            stage_range_next[s] = stage_range_reg[s];
            stage_bad_next[s]   = stage_bad_reg[s];
            if (sample_edge)
            begin
                if (s == 0)
                begin
                    stage_code_next[s]  = new_code;
                    stage_range_next[s] = new_range;
                    stage_bad_next[s]   = invalidate;
                end
                else
                begin
                    stage_code_next[s]  = stage_code_reg[PREV];
                    stage_range_next[s] = stage_range_reg[PREV];
                    stage_bad_next[s]   = stage_bad_reg[PREV] || invalidate;
                end
            end
        end

        // contents after reset are junk, so they are marked for discard
        always_ff @(posedge clk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                stage_code_reg[s]  <= 12'h000;
                stage_range_reg[s] <= 1'b0;
                stage_bad_reg[s]   <= 1'b1;
            end
            else
            begin
                stage_code_reg[s]  <= stage_code_next[s];
                stage_range_reg[s] <= stage_range_next[s];
                stage_bad_reg[s]   <= stage_bad_next[s];
            end
        end
    end

    // ========================================================
    // output pins
    // ========================================================
    logic [11:0] out_code_reg;
    logic [11:0] out_code_next;
    logic        out_range_reg;
    logic        out_range_next;
    logic        out_bad_reg;
    logic        out_bad_next;
    logic        out_msb_n_reg;
    logic        out_msb_n_next;
    logic        oe_reg;
    logic        oe_next;
    logic        push_reg;
    logic        push_next;
    logic        overrun_reg;
    logic        overrun_next;
    logic        fifo_in_ready;

    // last stage moves to the pins, word and flag together
    always_comb
    begin
        out_code_next  = sample_edge ? stage_code_reg[2] : out_code_reg;
        out_range_next = sample_edge ? stage_range_reg[2] : out_range_reg;
        out_bad_next   = sample_edge ? stage_bad_reg[2] : out_bad_reg;
        out_msb_n_next = ~out_code_next[adc_coding_pkg::MSB_POS];
        oe_next        = pin_level_reg[adc_coding_pkg::PIN_ENABLE];
        push_next      = sample_edge;
        overrun_next   = push_reg && !fifo_in_ready;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            out_code_reg  <= 12'h000;
            out_range_reg <= 1'b0;
            out_bad_reg   <= 1'b1;
            out_msb_n_reg <= 1'b1;
            oe_reg        <= 1'b0;
            push_reg      <= 1'b0;
            overrun_reg   <= 1'b0;
        end
        else
        begin
            out_code_reg  <= out_code_next;
            out_range_reg <= out_range_next;
            out_bad_reg   <= out_bad_next;
            out_msb_n_reg <= out_msb_n_next;
            oe_reg        <= oe_next;
            push_reg      <= push_next;
            overrun_reg   <= overrun_next;
        end
    end

    assign result_low_bits   = out_code_reg[10:0];
    assign result_msb        = out_code_reg[adc_coding_pkg::MSB_POS];
    assign result_msb_n      = out_msb_n_reg;
    assign out_of_range_flag = out_range_reg;
    assign result_discard    = out_bad_reg;
    assign result_oe         = oe_reg;
    assign stream_overrun    = overrun_reg;

    // ========================================================
    // result buffer
    // ========================================================
    // every result on the pins is also queued; a stalled reader loses later ones
    result_fifo #(
        .WIDTH (adc_coding_pkg::STREAM_WIDTH),
        .DEPTH (adc_coding_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .arst_n    (arst_n),
        .in_valid  (push_reg),
        .in_ready  (fifo_in_ready),
        .in_data   ({out_bad_reg, out_range_reg, out_code_reg}),
        .out_valid (stream_valid),
        .out_ready (stream_ready),
        .out_data  (stream_data)
    );

    // ========================================================
    // checks
    // ========================================================
    zero_code_a : assert property (@(posedge clk) disable iff (!arst_n)
        sample_edge && analog_in == 16'h0000 |=> stage_code_reg[0] == 12'h000)
        else $error("zero input not coded as zero");

    range_low_flag_a : assert property (@(posedge clk) disable iff (!arst_n)
        sample_edge && analog_s <= 16'sh07FF && analog_s >= 16'shF800
        |=> !stage_range_reg[0])
        else $error("range flag set for in-range input");

    sat_high_a : assert property (@(posedge clk) disable iff (!arst_n)
        sample_edge && analog_s > 16'sh07FF && analog_s <= 16'sh0C00
        |=> stage_range_reg[0] && stage_code_reg[0] == 12'h7FF)
        else $error("positive saturation wrong");

    sat_low_a : assert property (@(posedge clk) disable iff (!arst_n)
        sample_edge && analog_s < 16'shF800
        |=> stage_range_reg[0] && stage_code_reg[0] == 12'h800)
        else $error("negative saturation wrong");

    msb_pair_a : assert property (@(posedge clk) disable iff (!arst_n)
        result_msb_n == !result_msb)
        else $error("complement top bit mismatch");

    float_pins_a : assert property (@(posedge clk) disable iff (!arst_n)
        !pin_sync_reg[1][1] && !pin_sync_reg[1][2] |=> ##1 !result_oe)
        else $error("outputs driven while enable low");

    ref_flush_a : assert property (@(posedge clk) disable iff (!arst_n)
        invalidate |=> stage_bad_reg[0] && stage_bad_reg[1] && stage_bad_reg[2])
        else $error("reference change did not flush pipeline");

    fold_back_a : assert property (@(posedge clk) disable iff (!arst_n)
        sample_edge && analog_s > 16'sh0C00 |=> stage_code_reg[0] == 12'h000)
        else $error("overdrive did not fold back");

    edge_take_a : assert property (@(posedge clk) disable iff (!arst_n)
        sample_edge |-> !pin_level_reg[0] ##1 pin_level_reg[0])
        else $error("sample taken without rising edge");

    latency_a : assert property (@(posedge clk) disable iff (!arst_n)
        sample_edge |=> out_code_reg == $past(stage_code_reg[2])
            && stage_code_reg[2] == $past(stage_code_reg[1])
            && stage_code_reg[1] == $past(stage_code_reg[0]))
        else $error("result latency wrong");

    flag_with_word_a : assert property (@(posedge clk) disable iff (!arst_n)
        $changed(out_range_reg) |-> $past(sample_edge))
        else $error("range flag changed apart from word");

    saturate_cover : cover property (@(posedge clk) disable iff (!arst_n)
        sample_edge && analog_s > 16'sh07FF);

    flush_cover : cover property (@(posedge clk) disable iff (!arst_n)
        invalidate ##1 stage_bad_reg[2]);

    overrun_cover : cover property (@(posedge clk) disable iff (!arst_n)
        stream_overrun);

    float_cover : cover property (@(posedge clk) disable iff (!arst_n)
        $fell(result_oe));

endmodule // adc_output_coding

// File: tb/capture_partner.sv
// ============================================================
// capture_partner: downstream logic that clocks the converter
// ============================================================
// makes the sample clock and drive enable, takes stream words
// assumes the bench seeds $urandom and steers stall and enable_req
`timescale 1ns/1ps

module capture_partner #(
    parameter int HALF_PERIOD = 25
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic stall,
    input  wire logic enable_req,
    output logic      sample_clock_input,
    output logic      output_drive_enable,
    output logic      stream_ready
);
    int unsigned phase_cnt;

    // free-running sample clock, equal high and low, never paused
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            phase_cnt          <= 0;
            sample_clock_input <= 1'b0;
        end
        else if (phase_cnt == HALF_PERIOD - 1)
        begin
            phase_cnt          <= 0;
            sample_clock_input <= ~sample_clock_input;
        end
        else
            phase_cnt <= phase_cnt + 1;
    end

    // enable is up from time zero, before any sample is taken
    initial output_drive_enable = 1'b1;
    initial stream_ready = 1'b0;
    always @(posedge clk)
    begin
        output_drive_enable <= enable_req;
        stream_ready        <= !stall && ($urandom_range(3) != 0); // stalls at random
    end
endmodule // capture_partner

// File: tb/test_adc_output_coding.sv
// ============================================================
// test_adc_output_coding: self-checking bench for the block
// ============================================================
// notes each expected stream word in a queue, a monitor compares
// assumes the partner model makes the sample clock at 5 MHz
`timescale 1ns/1ps

`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED %0t value mismatch", $time); end end

module test_adc_output_coding;
    typedef struct {logic [13:0] w; bit junk; bit lost;} note_t;
    logic        clk = 1'b0, arst_n = 1'b0, stall = 1'b0, enable_req = 1'b1;
    logic        sample_clock_input, output_drive_enable, stream_ready, sclk_d = 1'b0;
    logic [15:0] analog_in = 16'h0000;
    logic [7:0]  reference_level = 8'h00;
    logic [10:0] result_low_bits;
    logic [13:0] stream_data;
    logic        result_msb, result_msb_n, out_of_range_flag, result_discard;
    logic        result_oe, stream_valid, stream_overrun;
    note_t       q[$], log_q[$];
    note_t       n, pn;
    int          err_total = 0, checks_done = 0, cycles = 0, overruns = 0, ov0;
    bit          ref_pend = 0;
    logic [15:0] edge_vals [9] = '{16'h0000, 16'h07FF, 16'h0800, 16'h0C00, 16'h0C01,
                                   16'hF800, 16'hF7FF, 16'h7FFF, 16'h8000};

    always #2 clk = ~clk;

    adc_output_coding dut (.clk(clk), .arst_n(arst_n), .sample_clock_input(sample_clock_input),
        .output_drive_enable(output_drive_enable), .analog_in(analog_in),
        .reference_level(reference_level), .result_low_bits(result_low_bits),
        .result_msb(result_msb), .result_msb_n(result_msb_n),
        .out_of_range_flag(out_of_range_flag), .result_discard(result_discard),
        .result_oe(result_oe), .stream_valid(stream_valid), .stream_ready(stream_ready),
        .stream_data(stream_data), .stream_overrun(stream_overrun));

    capture_partner partner (.clk(clk), .arst_n(arst_n), .stall(stall),
        .enable_req(enable_req), .sample_clock_input(sample_clock_input),
        .output_drive_enable(output_drive_enable), .stream_ready(stream_ready));

    // expected {discard, range flag, code} for one input
    function automatic logic [13:0] expect_word(logic [15:0] a);
        logic signed [15:0] s;
        s = a;
        if (s > adc_coding_pkg::FOLD_LIMIT)
            return {2'b01, adc_coding_pkg::CODE_MIDSCALE};
        if (s > adc_coding_pkg::POS_FULL_SCALE)
            return {2'b01, adc_coding_pkg::CODE_POS_FULL};
        if (s < adc_coding_pkg::NEG_FULL_SCALE)
            return {2'b01, adc_coding_pkg::CODE_NEG_FULL};
        return {2'b00, a[11:0]};
    endfunction

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // hold a value for one sample period, from one sample clock fall
    task automatic drive_sample(input logic [15:0] v, input bit bump_ref);
        do @(posedge clk); while (!(sclk_d && !sample_clock_input));
        analog_in <= v;
        if (bump_ref)
        begin
            reference_level <= reference_level + 8'h01;
            ref_pend = 1;
        end
    endtask

    // note a sample at each rise, mark drops, compare each taken word
    always @(posedge clk)
    begin
        sclk_d <= sample_clock_input;
        if (sample_clock_input && !sclk_d)
        begin
            // pins show the sample taken five rises back, counting this one
            if (log_q.size() >= 4)
            begin
                pn = log_q[log_q.size() - 4];
                `CHK(result_discard, pn.junk)
                if (!pn.junk)
                begin
                    `CHK({out_of_range_flag, result_msb, result_low_bits}, pn.w[12:0])
                    `CHK({result_msb_n, result_low_bits}, pn.w[11:0] ^ 12'h800)
                end
            end
            q.push_back('{expect_word(analog_in), ref_pend, 1'b0});
            log_q.push_back(q[q.size() - 1]);
            if (ref_pend)
            begin
                q[q.size() - 2].junk = 1;
                q[q.size() - 3].junk = 1;
                log_q[log_q.size() - 2].junk = 1;
                log_q[log_q.size() - 3].junk = 1;
            end
            ref_pend = 0;
        end
        if (stream_overrun === 1'b1)
        begin
            overruns++;
            q[q.size() - 4].lost = 1;
        end
        if (stream_valid === 1'b1 && stream_ready)
        begin
            while (q.size() > 0 && q[0].lost)
                void'(q.pop_front());
            n = q.pop_front();
            if (n.junk)
                `CHK(stream_data[13], 1'b1)
            else
                `CHK(stream_data, n.w)
            `CHK(result_msb_n, ~result_msb)
        end
    end

    // cut a hang short
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            report_and_stop();
        end
    end

    initial
    begin
        repeat (3)
        begin
            q.push_back('{14'h0000, 1'b1, 1'b0}); // pipeline holds reset junk
            log_q.push_back('{14'h0000, 1'b1, 1'b0});
        end
        void'($urandom(92063));
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        foreach (edge_vals[i])
            drive_sample(edge_vals[i], 0);
        $display("test coding boundaries done");
        repeat (30)
            drive_sample(16'($urandom_range(16'h1C00)) - 16'h0C00, 0);
        $display("test random samples done");
        drive_sample(16'h0123, 1);
        repeat (4)
            drive_sample(16'($urandom_range(16'h0FFF)) - 16'h0800, 0);
        $display("test reference change done");
        ov0 = overruns;
        stall <= 1'b1;
        repeat (20)
            drive_sample(16'($urandom_range(16'h0FFF)) - 16'h0800, 0);
        stall <= 1'b0;
        repeat (4)
            drive_sample(16'h0000, 0);
        `CHK(overruns - ov0, 20 - adc_coding_pkg::FIFO_DEPTH - 1)
        $display("test buffer overrun done");
        enable_req <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK(result_oe, 1'b0)
        enable_req <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK(result_oe, 1'b1)
        $display("test drive enable done");
        report_and_stop();
    end
endmodule // test_adc_output_coding
